// [shared/ccu_pkg.sv]
// constants, register map and types of the sixteen-channel capture/compare unit
package ccu_pkg;

    // ========================================
    // sizes
    localparam int unsigned NUM_CH   = 16;
    localparam int unsigned NUM_TMR  = 2;
    localparam int unsigned TMR_W    = 16;
    localparam int unsigned ADDR_W   = 8;
    localparam int unsigned PRE_W    = 9;
    localparam int unsigned CTRL_W   = 9;
    localparam int unsigned PAIRS    = 8;

    // ========================================
    // register byte offsets
    localparam logic [7:0] OFF_CTRL  = 8'h00;
    localparam logic [7:0] OFF_TMR0  = 8'h04;
    localparam logic [7:0] OFF_RLD0  = 8'h08;
    localparam logic [7:0] OFF_TMR1  = 8'h0C;
    localparam logic [7:0] OFF_RLD1  = 8'h10;
    localparam logic [7:0] OFF_STAT  = 8'h14;
    localparam logic [7:0] OFF_CLR   = 8'h18;
    localparam logic [7:0] OFF_EN    = 8'h1C;
    localparam logic [7:0] OFF_DBL   = 8'h20;
    localparam logic [7:0] OFF_PIN   = 8'h24;
    localparam logic [7:0] OFF_CH0   = 8'h40;
    localparam logic [1:0] CH_REGION = 2'h1;

    // ========================================
    // control register fields, per timer stride of four bits
    localparam int unsigned CTRL_RUN_BIT  = 0;
    localparam int unsigned CTRL_SEL_LSB  = 1;
    localparam int unsigned CTRL_STRIDE   = 4;
    localparam int unsigned CTRL_STAG_BIT = 8;
    localparam logic [8:0]  CTRL_RST      = 9'h000;

    // ========================================
    // count clock sources
    localparam logic [2:0] CLK_DIV1   = 3'h0;
    localparam logic [2:0] CLK_DIV8   = 3'h1;
    localparam logic [2:0] CLK_DIV64  = 3'h2;
    localparam logic [2:0] CLK_DIV512 = 3'h3;
    localparam logic [2:0] CLK_NEIGH  = 3'h4;
    localparam logic [2:0] CLK_EXT    = 3'h5;

    // ========================================
    // channel modes, field bits 19:16 of a channel register
    typedef enum logic [3:0] {
        CCU_OFF      = 4'h0,
        CCU_CAP_RISE = 4'h1,
        CCU_CAP_FALL = 4'h2,
        CCU_CAP_BOTH = 4'h3,
        CCU_CMP0     = 4'h4,
        CCU_CMP1     = 4'h5,
        CCU_CMP2     = 4'h6,
        CCU_CMP3     = 4'h7
    } ccu_mode_e;

    // channel register: value 15:0, mode 19:16, timer 20, single event 21
    typedef struct packed {
        logic             sgl;
        logic             tsel;
        logic [3:0]       mode;
        logic [TMR_W-1:0] val;
    } ccu_chan_s;

    localparam int unsigned CH_W = 22;

    typedef struct packed {
        logic              psel;
        logic              penable;
        logic              pwrite;
        logic [ADDR_W-1:0] paddr;
        logic [31:0]       pwdata;
    } ccu_apb_req_s;

endpackage

// [core/ccu_capture_compare_unit.sv]
// sixteen-channel capture/compare unit with two reloadable time bases on APB
// Overview of operation
// - sixteen channels, resolution one clock, or eight clocks in staggered operation.
// - two independent 16-bit timers, each with its own reload register.
// - timer clock is a prescaled system clock or neighbour upper timer overflow.
// - timers may also advance on rising edges of the external count inputs.
// - each channel picks either timer and either capture or compare.
// - each channel owns a pin: capture input or compare output.
// - capture edge copies the assigned timer value into the channel register.
// - every capture raises that channel's own interrupt request.
// - capture edge is rising, falling or both, chosen per channel.
// - compare channels compare continuously and act on equality by mode.
// - mode zero raises interrupts only, pin untouched, several per period.
// - mode one toggles the pin on every match, several per period.
// - mode two raises at most one interrupt per timer period.
// - mode three sets pin on match, clears on overflow, once per period.
// - double-register pairs share one pin; the high channel's match toggles it, the low channel's only in mode one.
// - single-event option stops a channel after one edge or pulse.
//
// Decided for this implementation: the address map and register access over APB.
`timescale 1ns/100ps
module ccu_capture_compare_unit (
    input  wire logic                       clk_sys,
    input  wire logic                       reset_n,
    input  wire ccu_pkg::ccu_apb_req_s      apb_req,
    output logic                            pready,
    output logic [31:0]                     prdata,
    output logic                            pslverr,
    input  wire logic [ccu_pkg::NUM_CH-1:0] pin_in,
    output logic [ccu_pkg::NUM_CH-1:0]      pin_out,
    output logic [ccu_pkg::NUM_CH-1:0]      pin_oe_n,
    input  wire logic [1:0]                 cnt_in,
    input  wire logic                       neighbour_upper_timer_ovf,
    output logic                            irq
);

    localparam int unsigned NC = ccu_pkg::NUM_CH;
    localparam int unsigned NT = ccu_pkg::NUM_TMR;
    localparam int unsigned TW = ccu_pkg::TMR_W;

    // ========================================
    // decoding helpers
    function automatic logic is_cap(input logic [3:0] m);
        return (m == ccu_pkg::CCU_CAP_RISE) || (m == ccu_pkg::CCU_CAP_FALL)
            || (m == ccu_pkg::CCU_CAP_BOTH);
    endfunction

    function automatic logic is_cmp(input logic [3:0] m);
        return (m == ccu_pkg::CCU_CMP0) || (m == ccu_pkg::CCU_CMP1)
            || (m == ccu_pkg::CCU_CMP2) || (m == ccu_pkg::CCU_CMP3);
    endfunction

    function automatic logic clk_pick(input logic [2:0] sel,
                                      input logic [ccu_pkg::PRE_W-1:0] pre,
                                      input logic nut, input logic ext);
        logic r;
        r = 1'b0;
        case (sel)
            ccu_pkg::CLK_DIV1:   r = 1'b1;
            ccu_pkg::CLK_DIV8:   r = &pre[2:0];
            ccu_pkg::CLK_DIV64:  r = &pre[5:0];
            ccu_pkg::CLK_DIV512: r = &pre;
            ccu_pkg::CLK_NEIGH:  r = nut;
            ccu_pkg::CLK_EXT:    r = ext;
            default:             r = 1'b0;
        endcase
        return r;
    endfunction

    // ========================================
    // state
    logic                          pready_r;
    logic [31:0]                   prdata_r;
    logic                          pslverr_r;
    logic                          irq_r;
    logic [ccu_pkg::CTRL_W-1:0]    ctrl_r;
    logic [NT-1:0][TW-1:0]         tmr_r;
    logic [NT-1:0][TW-1:0]         rld_r;
    logic [NC-1:0]                 stat_r;
    logic [NC-1:0]                 stat_nxt;
    logic [NC-1:0]                 en_r;
    logic [NC-1:0]                 en_nxt;
    logic [ccu_pkg::PAIRS-1:0]     dbl_r;
    logic [ccu_pkg::PRE_W-1:0]     pre_r;
    logic [1:0]                    cnt_in_r;
    logic [NC-1:0]                 pin_in_r;
    logic [NC-1:0]                 pin_out_r;
    logic [NC-1:0]                 pin_oe_n_r;
    ccu_pkg::ccu_chan_s [NC-1:0]   chan_r;
    logic [NC-1:0]                 eq_prev_r;
    logic [NC-1:0]                 done_r;
    logic [NC-1:0]                 lock_r;
    logic [NC-1:0]                 cap_evt;
    logic [NC-1:0]                 cmp_evt;
    logic [NC-1:0]                 eq_now;
    logic [NT-1:0]                 tick;
    logic [NT-1:0]                 ovf;
    logic [NT-1:0]                 tmr_wr;
    logic                          wr_fire;
    logic                          acc_start;
    logic                          stag_slot;
    logic [31:0]                   rd_data;
    logic                          rd_err;

    assign pready   = pready_r;
    assign prdata   = prdata_r;
    assign pslverr  = pslverr_r;
    assign irq      = irq_r;
    assign pin_out  = pin_out_r;
    assign pin_oe_n = pin_oe_n_r;

    // ========================================
    // APB slave: one wait state, answer registered
    assign acc_start = apb_req.psel & apb_req.penable & ~pready_r;
    assign wr_fire   = apb_req.psel & apb_req.penable & apb_req.pwrite & pready_r;

    always_comb begin
        rd_data = 32'h0000_0000;
        rd_err  = 1'b0;
        case (apb_req.paddr)
            ccu_pkg::OFF_CTRL: rd_data = {23'h000000, ctrl_r};
            ccu_pkg::OFF_TMR0: rd_data = {16'h0000, tmr_r[0]};
            ccu_pkg::OFF_RLD0: rd_data = {16'h0000, rld_r[0]};
            ccu_pkg::OFF_TMR1: rd_data = {16'h0000, tmr_r[1]};
            ccu_pkg::OFF_RLD1: rd_data = {16'h0000, rld_r[1]};
            ccu_pkg::OFF_STAT: rd_data = {16'h0000, stat_r};
            ccu_pkg::OFF_CLR:  rd_data = 32'h0000_0000;
            ccu_pkg::OFF_EN:   rd_data = {16'h0000, en_r};
            ccu_pkg::OFF_DBL:  rd_data = {24'h000000, dbl_r};
            ccu_pkg::OFF_PIN:  rd_data = {16'h0000, pin_in_r};
            default: begin
                if (apb_req.paddr[7:6] == ccu_pkg::CH_REGION && apb_req.paddr[1:0] == 2'h0) begin
                    rd_data = {10'h000, chan_r[apb_req.paddr[5:2]]};
                end else begin
                    rd_err = 1'b1;
                end
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            pready_r  <= 1'b0;
            prdata_r  <= 32'h0000_0000;
            pslverr_r <= 1'b0;
        end else begin
            pready_r  <= acc_start;
            prdata_r  <= (acc_start && !apb_req.pwrite) ? rd_data : 32'h0000_0000;
            pslverr_r <= acc_start & rd_err;
        end
    end

    // ========================================
    // software configuration registers
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            ctrl_r <= ccu_pkg::CTRL_RST;
            rld_r  <= '0;
            en_r   <= '0;
            dbl_r  <= '0;
        end else if (wr_fire) begin
            case (apb_req.paddr)
                ccu_pkg::OFF_CTRL: ctrl_r   <= apb_req.pwdata[ccu_pkg::CTRL_W-1:0];
                ccu_pkg::OFF_RLD0: rld_r[0] <= apb_req.pwdata[TW-1:0];
                ccu_pkg::OFF_RLD1: rld_r[1] <= apb_req.pwdata[TW-1:0];
                ccu_pkg::OFF_EN:   en_r     <= apb_req.pwdata[NC-1:0];
                ccu_pkg::OFF_DBL:  dbl_r    <= apb_req.pwdata[ccu_pkg::PAIRS-1:0];
                default: ;
            endcase
        end
    end

    // ========================================
    // prescaler and input registers
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            pre_r    <= '0;
            cnt_in_r <= '0;
            pin_in_r <= '0;
        end else begin
            pre_r    <= pre_r + 9'h001;
            cnt_in_r <= cnt_in;
            pin_in_r <= pin_in;
        end
    end

    // staggered operation lets the timers move only every eighth clock
    assign stag_slot = ~ctrl_r[ccu_pkg::CTRL_STAG_BIT] | (&pre_r[2:0]);

    // ========================================
    // time-base timers
    assign tmr_wr[0] = wr_fire && apb_req.paddr == ccu_pkg::OFF_TMR0;
    assign tmr_wr[1] = wr_fire && apb_req.paddr == ccu_pkg::OFF_TMR1;

    for (genvar t = 0; t < NT; t++) begin : g_tmr
        localparam int unsigned B = t * ccu_pkg::CTRL_STRIDE;
        assign tick[t] = ctrl_r[B + ccu_pkg::CTRL_RUN_BIT] & stag_slot
            & clk_pick(ctrl_r[B + ccu_pkg::CTRL_SEL_LSB +: 3], pre_r,
                       neighbour_upper_timer_ovf,
                       cnt_in[t] & ~cnt_in_r[t]);
        assign ovf[t] = tick[t] & (&tmr_r[t]);

        always_ff @(posedge clk_sys) begin
            if (!reset_n) begin
                tmr_r[t] <= '0;
            end else if (tmr_wr[t]) begin
                tmr_r[t] <= apb_req.pwdata[TW-1:0];
            end else if (ovf[t]) begin
                tmr_r[t] <= rld_r[t];
            end else if (tick[t]) begin
                tmr_r[t] <= tmr_r[t] + 16'h0001;
            end
        end
    end

    // ========================================
    // channel array
    for (genvar i = 0; i < NC; i++) begin : g_ch
        localparam logic [7:0] CH_OFF = ccu_pkg::OFF_CH0 + 8'(i * 4);
        logic        ch_wr;
        logic        rise;
        logic        fall;
        logic        paired_hi;
        logic        tog;
        logic        md_cmp;
        logic [3:0]  md;
        logic [TW-1:0] tv;

        assign md        = chan_r[i].mode;
        assign tv        = tmr_r[chan_r[i].tsel];
        assign ch_wr     = wr_fire && apb_req.paddr == CH_OFF;
        assign rise      = pin_in[i] & ~pin_in_r[i];
        assign fall      = ~pin_in[i] & pin_in_r[i];
        assign md_cmp    = is_cmp(md);
        assign eq_now[i] = md_cmp && (tv == chan_r[i].val);
        assign paired_hi = (i >= ccu_pkg::PAIRS) && dbl_r[i % ccu_pkg::PAIRS];

        assign cap_evt[i] = ~lock_r[i] & is_cap(md)
            & (((md == ccu_pkg::CCU_CAP_RISE) & rise)
             | ((md == ccu_pkg::CCU_CAP_FALL) & fall)
             | ((md == ccu_pkg::CCU_CAP_BOTH) & (rise | fall)));
        assign cmp_evt[i] = eq_now[i] & ~eq_prev_r[i] & ~lock_r[i]
            & ~(done_r[i] & ((md == ccu_pkg::CCU_CMP2)
                           | (md == ccu_pkg::CCU_CMP3)));

        always_ff @(posedge clk_sys) begin
            if (!reset_n) begin
                chan_r[i]    <= '0;
                eq_prev_r[i] <= 1'b0;
                done_r[i]    <= 1'b0;
                lock_r[i]    <= 1'b0;
            end else begin
                eq_prev_r[i] <= eq_now[i];
                if (ch_wr) begin
                    chan_r[i] <= apb_req.pwdata[ccu_pkg::CH_W-1:0];
                    done_r[i] <= 1'b0;
                    lock_r[i] <= 1'b0;
                end else begin
                    if (cap_evt[i]) begin
                        chan_r[i].val <= tv;
                    end
                    if (cmp_evt[i]) begin
                        done_r[i] <= 1'b1;
                    end else if (ovf[chan_r[i].tsel]) begin
                        done_r[i] <= 1'b0;
                    end
                    if ((cap_evt[i] | cmp_evt[i]) & chan_r[i].sgl) begin
                        lock_r[i] <= 1'b1;
                    end
                end
            end
        end

        // own pin toggles in mode one, except on a paired high channel; a low channel also follows its paired high one
        if (i < ccu_pkg::PAIRS) begin : g_lo
            assign tog = (cmp_evt[i] & (md == ccu_pkg::CCU_CMP1))
                | (dbl_r[i] & cmp_evt[i + ccu_pkg::PAIRS]);
        end else begin : g_hi
            assign tog = cmp_evt[i] & (md == ccu_pkg::CCU_CMP1) & ~paired_hi;
        end

        always_ff @(posedge clk_sys) begin
            if (!reset_n) begin
                pin_out_r[i]  <= 1'b0;
                pin_oe_n_r[i] <= 1'b1;
            end else begin
                if (md == ccu_pkg::CCU_CMP3 && cmp_evt[i] && !paired_hi) begin
                    pin_out_r[i] <= 1'b1;
                end else if (md == ccu_pkg::CCU_CMP3 && ovf[chan_r[i].tsel] && !paired_hi) begin
                    pin_out_r[i] <= 1'b0;
                end else if (tog) begin
                    pin_out_r[i] <= ~pin_out_r[i];
                end
                pin_oe_n_r[i] <= ~((((md == ccu_pkg::CCU_CMP1) | (md == ccu_pkg::CCU_CMP3))
                    & ~paired_hi) | ((i < ccu_pkg::PAIRS) & dbl_r[i % ccu_pkg::PAIRS]));
            end
        end
    end

    // ========================================
    // interrupt status: events win over a clear in the same cycle
    // enable as it will stand after this cycle, so irq follows a fresh enable at once
    assign en_nxt = (wr_fire && apb_req.paddr == ccu_pkg::OFF_EN)
        ? apb_req.pwdata[NC-1:0] : en_r;

    always_comb begin
        stat_nxt = stat_r;
        if (wr_fire && apb_req.paddr == ccu_pkg::OFF_CLR) begin
            stat_nxt = stat_r & ~apb_req.pwdata[NC-1:0];
        end
        stat_nxt = stat_nxt | cap_evt | cmp_evt;
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            stat_r <= '0;
            irq_r  <= 1'b0;
        end else begin
            stat_r <= stat_nxt;
            irq_r  <= |(stat_nxt & en_nxt);
        end
    end

    // ========================================
    // assertions
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);

    property p_cap_val;
        cap_evt[2] && !g_ch[2].ch_wr |=> chan_r[2].val == $past(g_ch[2].tv);
    endproperty
    a_cap_val: assert property (p_cap_val) else $error("capture value wrong");

    property p_cap_irq;
        cap_evt[1] |=> stat_r[1];
    endproperty
    a_cap_irq: assert property (p_cap_irq) else $error("capture flag missing");

    property p_reload;
        ovf[0] && !tmr_wr[0] |=> tmr_r[0] == $past(rld_r[0]);
    endproperty
    a_reload: assert property (p_reload) else $error("reload not taken");

    property p_count;
        tick[1] && !ovf[1] && !tmr_wr[1] |=> tmr_r[1] == $past(tmr_r[1]) + 16'h0001;
    endproperty
    a_count: assert property (p_count) else $error("timer did not count");

    property p_toggle;
        cmp_evt[4] && chan_r[4].mode == ccu_pkg::CCU_CMP1 && !dbl_r[4]
            |=> pin_out_r[4] != $past(pin_out_r[4]);
    endproperty
    a_toggle: assert property (p_toggle) else $error("mode one pin did not toggle");

    property p_set_high;
        cmp_evt[5] && chan_r[5].mode == ccu_pkg::CCU_CMP3 |=> pin_out_r[5];
    endproperty
    a_set_high: assert property (p_set_high) else $error("mode three pin not set");

    property p_once;
        done_r[11] && chan_r[11].mode == ccu_pkg::CCU_CMP2 && !ovf[chan_r[11].tsel]
            && !g_ch[11].ch_wr |=> !cmp_evt[11];
    endproperty
    a_once: assert property (p_once) else $error("second mode two event");

    property p_single;
        cmp_evt[6] && chan_r[6].sgl && !g_ch[6].ch_wr |=> !cmp_evt[6] [*3];
    endproperty
    a_single: assert property (p_single) else $error("single event repeated");

    property p_first_eq;
        chan_r[10].mode == ccu_pkg::CCU_CMP0 && !lock_r[10] && $stable(chan_r[10])
            && $past(tmr_r[chan_r[10].tsel]) != chan_r[10].val
            && tmr_r[chan_r[10].tsel] == chan_r[10].val |=> stat_r[10];
    endproperty
    a_first_eq: assert property (p_first_eq) else $error("match not flagged");

    property p_irq_out;
        |(stat_r & en_r) |-> irq_r;
    endproperty
    a_irq_out: assert property (p_irq_out) else $error("interrupt output low");

    c_capture: cover property (cap_evt[3]);
    c_toggle:  cover property (cmp_evt[4] ##[1:100] cmp_evt[4]);
    c_reload:  cover property (ovf[0] ##1 tmr_r[0] != 16'h0000);
    c_irq:     cover property (irq_r ##1 !irq_r);

endmodule

// [verif/ccu_pin_model.sv]
// outside world of the channel pins: resolves each pin from unit drive and outside level
`timescale 1ns/100ps
module ccu_pin_model (
    input  wire logic [15:0] pin_out,
    input  wire logic [15:0] pin_oe_n,
    input  wire logic [15:0] ext_lvl,
    output logic [15:0]      pin_in
);
    // ========================================
    // pin resolution
    // the unit owns a pin only while its enable is low, else the outside level shows
    always_comb begin
        for (int i = 0; i < 16; i++) begin
            pin_in[i] = pin_oe_n[i] ? ext_lvl[i] : pin_out[i];
        end
    end
endmodule

// [verif/testbench.sv]
// self-checking bench of the capture/compare unit over APB and its channel pins
`timescale 1ns/100ps
`define CHK(g, x) begin num_checks++; if ((g) !== (x)) begin miscompares++; \
    $display("Error %0t: got %h expected %h", $time, g, x); end end
module testbench;
    logic                  clk_sys;
    logic                  reset_n;
    ccu_pkg::ccu_apb_req_s apb_req;
    logic                  pready;
    logic                  pslverr;
    logic                  irq;
    logic                  nut_ovf;
    logic [31:0]           prdata;
    logic [15:0]           pin_in;
    logic [15:0]           pin_out;
    logic [15:0]           pin_oe_n;
    logic [15:0]           ext_lvl;
    logic [15:0]           v;
    logic [15:0]           w;
    logic [1:0]            cnt_in;
    logic [32:0]           exp_q[$];
    logic [32:0]           e;
    int                    miscompares = 0;
    int                    num_checks = 0;
    int                    cyc = 0;
    int                    n;
    int                    t2;
    int                    t4;
    int                    t5;
    int                    t6;

    ccu_capture_compare_unit DUT (
        .clk_sys                   (clk_sys),
        .reset_n                   (reset_n),
        .apb_req                   (apb_req),
        .pready                    (pready),
        .prdata                    (prdata),
        .pslverr                   (pslverr),
        .pin_in                    (pin_in),
        .pin_out                   (pin_out),
        .pin_oe_n                  (pin_oe_n),
        .cnt_in                    (cnt_in),
        .neighbour_upper_timer_ovf (nut_ovf),
        .irq                       (irq)
    );

    ccu_pin_model PIN (
        .pin_out  (pin_out),
        .pin_oe_n (pin_oe_n),
        .ext_lvl  (ext_lvl),
        .pin_in   (pin_in)
    );

    // ========================================
    // clock, watchdog, verdict, answer monitor
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    task automatic end_sim;
        if (miscompares == 0 && num_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 20000) begin
            miscompares++;
            $display("Error %0t: timeout", $time);
            end_sim();
        end
    end

    // every answered transfer takes the oldest note of {error, read data}
    always @(posedge clk_sys) begin
        if (pready === 1'b1) begin
            e = exp_q.pop_front();
            `CHK({pslverr, prdata}, e)
        end
    end

    // ========================================
    // bus and pin helpers
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       input logic [32:0] x);
        exp_q.push_back(x);
        @(posedge clk_sys);
        apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
        @(posedge clk_sys);
        apb_req.penable <= 1'b1;
        do @(posedge clk_sys); while (pready !== 1'b1);
        apb_req.psel    <= 1'b0;
        apb_req.penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 33'h0_0000_0000);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0000_0000, {1'b0, x});
    endtask

    task automatic chan(input int ch, input logic sgl, input logic [3:0] md,
                        input logic [15:0] val);
        wr(ccu_pkg::OFF_CH0 + 8'(4 * ch), {10'h000, sgl, 1'b0, md, val});
    endtask

    task automatic cnt(input int ch, input int cycles, output int t);
        logic p;
        t = 0;
        p = pin_out[ch];
        repeat (cycles) begin
            @(posedge clk_sys);
            #1;
            if (pin_out[ch] !== p) t++;
            p = pin_out[ch];
        end
    endtask

    task automatic edge_to(input int ch, input logic lvl);
        @(posedge clk_sys);
        ext_lvl[ch] <= lvl;
        repeat (4) @(posedge clk_sys);
    endtask

    // ========================================
    // main sequence
    initial begin
        apb_req = '0;
        reset_n = 1'b0;
        ext_lvl = 16'h0000;
        cnt_in  = 2'h0;
        nut_ovf = 1'b0;
        n = $urandom(75);
        repeat (5) @(posedge clk_sys);
        reset_n <= 1'b1;
        rd(ccu_pkg::OFF_CTRL, 32'h0000_0000);
        `CHK(pin_oe_n, 16'hFFFF)
        apb(1'b0, 8'h30, 32'h0000_0000, {1'b1, 32'h0000_0000});
        // capture on each edge choice, stopped timer rewritten between edges
        for (int m = 1; m <= 3; m++) begin
            v = 16'($urandom);
            w = ~v;
            wr(ccu_pkg::OFF_EN, 32'h0000_0000);
            wr(ccu_pkg::OFF_TMR0, {16'h0000, v});
            chan(m, 1'b0, 4'(m), 16'h0000);
            edge_to(m, 1'b1);
            wr(ccu_pkg::OFF_TMR0, {16'h0000, w});
            edge_to(m, 1'b0);
            `CHK(irq, 1'b0)
            `CHK(pin_oe_n[m], 1'b1)
            rd(ccu_pkg::OFF_CH0 + 8'(4 * m), {12'h000, 4'(m), (m == 1) ? v : w});
            wr(ccu_pkg::OFF_EN, 32'h0000_FFFF);
            repeat (2) @(posedge clk_sys);
            `CHK(irq, 1'b1)
            rd(ccu_pkg::OFF_STAT, 32'h1 << m);
            wr(ccu_pkg::OFF_CLR, 32'h1 << m);
            rd(ccu_pkg::OFF_STAT, 32'h0000_0000);
            `CHK(irq, 1'b0)
        end
        // compare modes on a sixteen-cycle period
        wr(ccu_pkg::OFF_EN, 32'h0000_0000);
        wr(ccu_pkg::OFF_RLD0, 32'h0000_FFF0);
        wr(ccu_pkg::OFF_TMR0, 32'h0000_FFF0);
        chan(2, 1'b0, ccu_pkg::CCU_CMP1, 16'hFFF1);
        chan(10, 1'b0, ccu_pkg::CCU_CMP0, 16'hFFF9);
        chan(4, 1'b0, ccu_pkg::CCU_CMP1, 16'hFFF4);
        chan(5, 1'b0, ccu_pkg::CCU_CMP3, 16'hFFF8);
        chan(6, 1'b1, ccu_pkg::CCU_CMP1, 16'hFFFE);
        chan(11, 1'b0, ccu_pkg::CCU_CMP2, 16'hFFF3);
        wr(ccu_pkg::OFF_DBL, 32'h0000_0004);
        wr(ccu_pkg::OFF_CTRL, 32'h0000_0001);
        fork
            cnt(2, 160, t2);
            cnt(4, 160, t4);
            cnt(5, 160, t5);
            cnt(6, 160, t6);
        join
        `CHK(t4, 10)
        `CHK(t2, 20)
        `CHK(t5, 20)
        `CHK(t6, 1)
        `CHK(pin_out[11], 1'b0)
        `CHK(pin_oe_n[4], 1'b0)
        rd(ccu_pkg::OFF_STAT, 32'h0000_0C74);
        // divided and staggered count clocks stretch the period to 128 cycles
        for (int i = 0; i < 2; i++) begin
            wr(ccu_pkg::OFF_CTRL, (i == 0) ? 32'h0000_0003 : 32'h0000_0101);
            cnt(4, 1280, t4);
            `CHK(t4, 10)
        end
        // timer one counts neighbour overflow pulses, then external count edges
        for (int s = 0; s < 2; s++) begin
            n = $urandom_range(9, 3);
            wr(ccu_pkg::OFF_CTRL, 32'h0000_0000);
            wr(ccu_pkg::OFF_TMR1, 32'h0000_0005);
            wr(ccu_pkg::OFF_CTRL, (s == 0) ? 32'h0000_0090 : 32'h0000_00B0);
            repeat (n) begin
                @(posedge clk_sys);
                if (s == 0) nut_ovf <= 1'b1;
                else cnt_in[1] <= 1'b1;
                @(posedge clk_sys);
                nut_ovf   <= 1'b0;
                cnt_in[1] <= 1'b0;
                @(posedge clk_sys);
            end
            wr(ccu_pkg::OFF_CTRL, 32'h0000_0000);
            rd(ccu_pkg::OFF_TMR1, 32'(5 + n));
        end
        // channel one captures from the stopped timer one, which holds 5 + n
        wr(ccu_pkg::OFF_CH0 + 8'h04, {12'h001, ccu_pkg::CCU_CAP_RISE, 16'h0000});
        edge_to(1, 1'b1);
        rd(ccu_pkg::OFF_CH0 + 8'h04, {12'h001, ccu_pkg::CCU_CAP_RISE, 16'(5 + n)});
        repeat (2) @(posedge clk_sys);
        end_sim();
    end
endmodule
